// File: rtl/scs_pkg.sv
// Constants, register map and field layout of the serial port block.
// Assumes a 32-bit APB slave on a 12-bit byte address, one clock.
package scs_pkg;

  // ----------------------------------------------------------------
  // Bus and data widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned RATE_W = 2;
  localparam logic [2:0]  BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_ONE_ADDR = 12'h0e8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR    = 12'h0ec;
  localparam logic [ADDR_W-1:0] TX_ADDR      = 12'h0f0;
  localparam logic [ADDR_W-1:0] RX_ADDR      = 12'h0f4;
  localparam logic [ADDR_W-1:0] STAT_ADDR    = 12'h0f8;
  localparam logic [ADDR_W-1:0] MASK_ADDR    = 12'h0fc;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_SRC_BIT   = 5;
  localparam int unsigned CFG_AUTO_BIT  = 4;
  localparam int unsigned CFG_SSEN_BIT  = 3;
  localparam int unsigned CFG_OFW_BIT   = 2;
  localparam int unsigned CFG_RATE_LSB  = 0;
  localparam logic [7:0]  CFG_RESET     = 8'h10;
  localparam logic [7:0]  CFG_WMASK     = 8'h3f;
  localparam int unsigned CTRL_W        = 3;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_MS_BIT   = 1;
  localparam int unsigned CTRL_CONT_BIT = 2;
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_SPI       = 0;
  localparam int unsigned IRQ_OVF       = 1;
  localparam int unsigned IRQ_DONE      = 2;
  localparam int unsigned STAT_RXF_BIT  = 8;
  localparam int unsigned STAT_TXV_BIT  = 9;
  localparam int unsigned STAT_BUSY_BIT = 10;

  // ----------------------------------------------------------------
  // Clock dividers of the rate field
  // ----------------------------------------------------------------
  localparam logic [6:0] DIV_RATE0 = 7'h08;
  localparam logic [6:0] DIV_RATE1 = 7'h10;
  localparam logic [6:0] DIV_RATE2 = 7'h20;
  localparam logic [6:0] DIV_RATE3 = 7'h40;

  // Half of the divider, in core cycles
  function automatic logic [5:0] scs_half(input logic [RATE_W-1:0] r);
    logic [6:0] div;
    case (r)
      2'h0:    div = DIV_RATE0;
      2'h1:    div = DIV_RATE1;
      2'h2:    div = DIV_RATE2;
      default: div = DIV_RATE3;
    endcase
    return div[6:1];
  endfunction

  function automatic logic scs_hit(input logic [ADDR_W-1:0] a);
    return (a == CFG_ONE_ADDR) || (a == CTRL_ADDR) || (a == TX_ADDR) ||
           (a == RX_ADDR) || (a == STAT_ADDR) || (a == MASK_ADDR);
  endfunction

endpackage

// File: rtl/scs_sync.sv
// Two-flop synchroniser for the pin inputs.
// Assumes the inputs change freely relative to pclk.
`timescale 1ns/10ps
module scs_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scs_sync_st_t;

  scs_sync_st_t st_q;
  scs_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

// File: rtl/scs_sclk_div.sv
// Half-period tick generator for the master serial clock.
// Assumes run and rate come from logic on pclk.
`timescale 1ns/10ps
module scs_sclk_div
  import scs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              run,
  input  wire logic [RATE_W-1:0] rate,
  output logic                   tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } scs_div_st_t;

  scs_div_st_t st_q;
  scs_div_st_t st_d;
  logic        wrap;

  assign wrap = (st_q.cnt == (scs_half(rate) - 6'h01));

  always_comb begin
    st_d      = st_q;
    st_d.tick = run && wrap;
    if (!run || wrap) begin
      st_d.cnt = 6'h00;
    end else begin
      st_d.cnt = st_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule

// File: rtl/scs_port.sv
// Serial port with APB registers: configuration, transfer engine, interrupt.
// Assumes APB3 master on pclk; pins are asynchronous to pclk.
`timescale 1ns/10ps
module scs_port
  import scs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              sclk_i,
  output logic                   sclk_o,
  output logic                   sclk_oe,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe,
  input  wire logic              ss_n_i,
  output logic                   ss_n_o,
  output logic                   ss_n_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_SHIFT} scs_mst_t;

  typedef struct packed {
    logic [7:0]        cfg;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0]        tx_hold;
    logic              tx_valid;
    logic [7:0]        rx_data;
    logic              rx_full;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_mask;
    scs_mst_t          mst;
    logic [2:0]        bit_cnt;
    logic [7:0]        tx_shift;
    logic [7:0]        rx_shift;
    logic              s_loaded;
    logic              sclk_prev;
    logic              sclk_o;
    logic              sclk_oe;
    logic              mosi_o;
    logic              mosi_oe;
    logic              miso_o;
    logic              miso_oe;
    logic              ss_n_o;
    logic              ss_n_oe;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              irq;
  } scs_state_t;

  scs_state_t q;
  scs_state_t d;

  logic [3:0]        pin_s;
  logic              sclk_s;
  logic              mosi_s;
  logic              miso_s;
  logic              ss_n_s;
  logic              tick;
  logic              acc;
  logic              wr_en;
  logic              rd_en;
  logic              wr_cfg;
  logic              wr_ctrl;
  logic              wr_tx;
  logic              wr_stat;
  logic              wr_mask;
  logic              rd_rx;
  logic              en;
  logic              role;
  logic              cont;
  logic              src;
  logic              auto_ss;
  logic              ss_en;
  logic              ofw;
  logic [RATE_W-1:0] rate;
  logic              run;
  logic              s_sel;
  logic              s_rise;
  logic              s_fall;
  logic              byte_done;
  logic              tx_load;
  logic              rx_store;
  logic [7:0]        rx_byte;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  w1c;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] rd_word;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock divider
  // ----------------------------------------------------------------
  scs_sync #(
    .W (4)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sclk_i, mosi_i, miso_i, ss_n_i}),
    .q       (pin_s)
  );

  assign {sclk_s, mosi_s, miso_s, ss_n_s} = pin_s;

  scs_sclk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .rate    (rate),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic acc_to(input logic a_en, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] target);
    return a_en && (a == target);
  endfunction

  assign acc     = psel && penable && q.pready;
  assign wr_en   = acc && pwrite;
  assign rd_en   = acc && !pwrite;
  assign wr_cfg  = acc_to(wr_en, paddr, CFG_ONE_ADDR);
  assign wr_ctrl = acc_to(wr_en, paddr, CTRL_ADDR);
  assign wr_tx   = acc_to(wr_en, paddr, TX_ADDR);
  assign wr_stat = acc_to(wr_en, paddr, STAT_ADDR);
  assign wr_mask = acc_to(wr_en, paddr, MASK_ADDR);
  assign rd_rx   = acc_to(rd_en, paddr, RX_ADDR);

  assign en      = q.ctrl[CTRL_EN_BIT];
  assign role    = q.ctrl[CTRL_MS_BIT];
  assign cont    = q.ctrl[CTRL_CONT_BIT];
  assign src     = q.cfg[CFG_SRC_BIT];
  assign auto_ss = q.cfg[CFG_AUTO_BIT];
  assign ss_en   = q.cfg[CFG_SSEN_BIT];
  assign ofw     = q.cfg[CFG_OFW_BIT];
  assign rate    = q.cfg[CFG_RATE_LSB +: RATE_W];

  assign run    = en && role && (q.mst == ST_SHIFT);
  assign s_sel  = en && !role && (!ss_en || !ss_n_s);
  assign s_rise = sclk_s && !q.sclk_prev;
  assign s_fall = !sclk_s && q.sclk_prev;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    byte_done = 1'b0;
    tx_load   = 1'b0;
    rx_byte   = q.rx_shift;
    // Master engine, mode 0: sample on rise, shift on fall
    if (!(en && role)) begin
      d.mst    = ST_IDLE;
      d.sclk_o = 1'b0;
    end else if (run && tick) begin
      if (!q.sclk_o) begin
        d.sclk_o   = 1'b1;
        d.rx_shift = {q.rx_shift[BYTE_W-2:0], miso_s};
      end else begin
        d.sclk_o = 1'b0;
        if (q.bit_cnt == BIT_LAST) begin
          byte_done = 1'b1;
          if (cont && q.tx_valid) begin
            tx_load    = 1'b1;
            d.tx_shift = q.tx_hold;
            d.bit_cnt  = 3'h0;
          end else begin
            d.mst = ST_IDLE;
          end
        end else begin
          d.tx_shift = {q.tx_shift[BYTE_W-2:0], 1'b0};
          d.bit_cnt  = q.bit_cnt + 3'h1;
        end
      end
    end else if (q.mst == ST_IDLE && q.tx_valid) begin
      tx_load    = 1'b1;
      d.tx_shift = q.tx_hold;
      d.bit_cnt  = 3'h0;
      d.mst      = ST_SHIFT;
    end
    // Slave engine
    if (!role) begin
      if (!s_sel) begin
        d.bit_cnt  = 3'h0;
        d.s_loaded = 1'b0;
      end else begin
        if (!q.s_loaded && q.bit_cnt == 3'h0 && !s_rise) begin
          tx_load    = q.tx_valid;
          d.tx_shift = q.tx_valid ? q.tx_hold : 8'h00;
          d.s_loaded = 1'b1;
        end
        if (s_rise) begin
          d.rx_shift = {q.rx_shift[BYTE_W-2:0], mosi_s};
          if (q.bit_cnt == BIT_LAST) begin
            byte_done  = 1'b1;
            rx_byte    = {q.rx_shift[BYTE_W-2:0], mosi_s};
            d.bit_cnt  = 3'h0;
            d.s_loaded = 1'b0;
          end else begin
            d.bit_cnt = q.bit_cnt + 3'h1;
          end
        end else if (s_fall && q.bit_cnt != 3'h0) begin
          d.tx_shift = {q.tx_shift[BYTE_W-2:0], 1'b0};
        end
      end
    end
    d.sclk_prev = sclk_s;
    rx_store = byte_done && (!q.rx_full || ofw);
    if (rx_store) begin
      d.rx_data = rx_byte;
    end
    d.rx_full  = (q.rx_full && !rd_rx) || rx_store;
    d.tx_valid = (q.tx_valid && !tx_load) || wr_tx;
    if (wr_tx) begin
      d.tx_hold = pwdata[BYTE_W-1:0];
    end
    if (wr_cfg) begin
      d.cfg = pwdata[7:0] & CFG_WMASK;
    end
    if (wr_ctrl) begin
      d.ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr_mask) begin
      d.irq_mask = pwdata[IRQ_W-1:0];
    end
    ev           = '0;
    ev[IRQ_SPI]  = src ? tx_load : rx_store;
    ev[IRQ_OVF]  = byte_done && q.rx_full;
    ev[IRQ_DONE] = byte_done;
    w1c          = wr_stat ? pwdata[IRQ_W-1:0] : '0;
    d.irq_st     = (q.irq_st & ~w1c) | ev;
    d.irq        = |(d.irq_st & d.irq_mask);
    d.ss_n_o  = role ? (auto_ss ? (d.mst != ST_SHIFT) : 1'b0) : 1'b1;
    d.ss_n_oe = role;
    d.sclk_oe = role;
    d.mosi_oe = role && en;
    d.mosi_o  = d.tx_shift[BYTE_W-1];
    d.miso_oe = s_sel;
    d.miso_o  = d.tx_shift[BYTE_W-1];
    // APB: no wait state, data latched in setup
    stat_word                = '0;
    stat_word[IRQ_W-1:0]     = q.irq_st;
    stat_word[STAT_RXF_BIT]  = q.rx_full;
    stat_word[STAT_TXV_BIT]  = q.tx_valid;
    stat_word[STAT_BUSY_BIT] = (q.mst == ST_SHIFT);
    case (paddr)
      CFG_ONE_ADDR: rd_word = {24'h000000, q.cfg & CFG_WMASK};
      CTRL_ADDR:    rd_word = {29'h00000000, q.ctrl};
      TX_ADDR:      rd_word = {24'h000000, q.tx_hold};
      RX_ADDR:      rd_word = {24'h000000, q.rx_data};
      STAT_ADDR:    rd_word = stat_word;
      MASK_ADDR:    rd_word = {29'h00000000, q.irq_mask};
      default:      rd_word = '0;
    endcase
    d.pready  = psel && !penable;
    d.pslverr = psel && !penable && !scs_hit(paddr);
    if (psel && !penable) begin
      d.prdata = rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.cfg    <= CFG_RESET;
      q.ss_n_o <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign irq     = q.irq;
  assign sclk_o  = q.sclk_o;
  assign sclk_oe = q.sclk_oe;
  assign mosi_o  = q.mosi_o;
  assign mosi_oe = q.mosi_oe;
  assign miso_o  = q.miso_o;
  assign miso_oe = q.miso_oe;
  assign ss_n_o  = q.ss_n_o;
  assign ss_n_oe = q.ss_n_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_single_end;
    byte_done && role && auto_ss && !(cont && q.tx_valid);
  endsequence

  sequence s_cont_end;
    byte_done && role && auto_ss && cont && q.tx_valid;
  endsequence

  property p_irq_rx;
    @(posedge pclk) disable iff (!presetn)
    (rx_store && !src) |=> q.irq_st[IRQ_SPI];
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx full event lost");

  property p_irq_tx;
    @(posedge pclk) disable iff (!presetn)
    (tx_load && src) |=> q.irq_st[IRQ_SPI];
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx empty event lost");

  property p_manual_ss;
    @(posedge pclk) disable iff (!presetn)
    (role && !auto_ss) |=> !q.ss_n_o && q.ss_n_oe;
  endproperty
  a_manual_ss: assert property (p_manual_ss) else $error("manual select not low");

  property p_single_ss;
    @(posedge pclk) disable iff (!presetn)
    s_single_end |=> q.ss_n_o && (q.mst == ST_IDLE);
  endproperty
  a_single_ss: assert property (p_single_ss) else $error("select not released");

  property p_cont_ss;
    @(posedge pclk) disable iff (!presetn)
    s_cont_end |=> !q.ss_n_o && (q.mst == ST_SHIFT);
  endproperty
  a_cont_ss: assert property (p_cont_ss) else $error("select dropped mid transfer");

  property p_ss_busy;
    @(posedge pclk) disable iff (!presetn)
    (role && auto_ss) |=> (q.ss_n_o == (q.mst != ST_SHIFT));
  endproperty
  a_ss_busy: assert property (p_ss_busy) else $error("select does not track busy");

  property p_slave_gate;
    @(posedge pclk) disable iff (!presetn)
    (!role && ss_en && ss_n_s) |=> (q.bit_cnt == 3'h0) && !q.miso_oe;
  endproperty
  a_slave_gate: assert property (p_slave_gate) else $error("unselected slave shifted");

  property p_ovf_drop;
    @(posedge pclk) disable iff (!presetn)
    (byte_done && q.rx_full && !ofw && !rd_rx) |=> (q.rx_data == $past(q.rx_data));
  endproperty
  a_ovf_drop: assert property (p_ovf_drop) else $error("unread byte overwritten");

  property p_ovf_write;
    @(posedge pclk) disable iff (!presetn)
    (byte_done && q.rx_full && ofw) |=> (q.rx_data == $past(rx_byte)) && q.rx_full;
  endproperty
  a_ovf_write: assert property (p_ovf_write) else $error("overflow byte not stored");

  property p_rate0;
    @(posedge pclk) disable iff (!presetn)
    (tick && run && rate == 2'h0) ##1 (run && rate == 2'h0) [*3] |=> tick;
  endproperty
  a_rate0: assert property (p_rate0) else $error("divide by 8 period wrong");

  property p_reset_cfg;
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (q.cfg == CFG_RESET) && q.ss_n_o && !q.irq;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reset value wrong");

  property p_role;
    @(posedge pclk) disable iff (!presetn)
    role |=> q.sclk_oe && !q.miso_oe;
  endproperty
  a_role: assert property (p_role) else $error("master role not driving clock");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (q.pready && !pwrite && paddr == CFG_ONE_ADDR) |-> (q.prdata[DATA_W-1:6] == '0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule

// File: testbench/scs_spi_slave.sv
// Behavioural serial slave facing the port in master role.
// Assumes mode 0 framing and an active-low select from the port.
`timescale 1ns/10ps
module scs_spi_slave (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh;
  logic [2:0] cnt;

  initial begin
    miso = 1'b0;
    got = 8'h00;
    sh = 8'h00;
    cnt = 3'h0;
  end

  // --------------------------------------------------------------
  // Framing
  // --------------------------------------------------------------
  always @(negedge ss_n) begin
    sh = reply;
    cnt = 3'h0;
    miso = reply[7];
  end

  // Released line: no pull, show the inverse of the last bit
  always @(posedge ss_n) begin
    miso = ~miso;
  end

  always @(posedge sclk) begin
    if (!ss_n) begin
      got = {got[6:0], mosi};
    end
  end

  // Next bit on the falling edge, reload after each byte
  always @(negedge sclk) begin
    if (!ss_n) begin
      cnt = cnt + 3'h1;
      if (cnt == 3'h0) begin
        sh = reply;
      end else begin
        sh = {sh[6:0], 1'b0};
      end
      miso = sh[7];
    end
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench of the serial port: APB master and slave model.
// Assumes scs_pkg, the port and the slave model are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb
  import scs_pkg::*;
;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] x;
    logic              e;
  } scs_row_t;

  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              irq, er, sp, sclk_o, sclk_oe, mosi_o, mosi_oe;
  logic              miso_i, miso_o, miso_oe, ss_n_o, ss_n_oe;
  logic [7:0]        reply, got;
  int                mismatches, num_checks, cyc, lst, per, rises;
  scs_row_t          rows [6];

  scs_port scs_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sclk_i(1'b0), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(1'b0),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_i(1'b1), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));

  scs_spi_slave scs_spi_slave_inst (.sclk(sclk_o & sclk_oe), .mosi(mosi_o),
    .ss_n(ss_n_oe ? ss_n_o : 1'b1), .reply(reply), .miso(miso_i), .got(got));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end

  // --------------------------------------------------------------
  // Serial clock period and rising edges while selected
  // --------------------------------------------------------------
  always @(negedge pclk) begin
    cyc++;
    if (sclk_o === 1'b1 && sp === 1'b0) begin
      per = cyc - lst;
      lst = cyc;
      if (ss_n_o === 1'b0) begin
        rises++;
      end
    end
    sp = sclk_o;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        end_sim();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ss(input logic v);
    int n;
    n = 0;
    while (ss_n_o !== v && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    `CHK(ss_n_o, v)
  endtask

  task automatic go(input logic [7:0] tx, input logic [7:0] rp);
    reply = rp;
    rises = 0;
    apb(1'b1, TX_ADDR, {24'h0, tx});
    wait_ss(1'b0);
  endtask

  task automatic fin(input logic [7:0] tx, input int nb);
    wait_ss(1'b1);
    repeat (3) @(negedge pclk);
    `CHK(got, tx)
    `CHK(rises, nb)
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    reply = 8'h00;
    presetn = 1'b0;
    rows[0] = '{CFG_ONE_ADDR, 32'hffffffff, 32'h3f, 1'b0};
    rows[1] = '{CFG_ONE_ADDR, 32'h2d, 32'h2d, 1'b0};
    rows[2] = '{MASK_ADDR, 32'h7, 32'h7, 1'b0};
    rows[3] = '{CFG_ONE_ADDR, 32'h10, 32'h10, 1'b0};
    rows[4] = '{12'h100, 32'h5, 32'h0, 1'b1};
    rows[5] = '{12'h0ea, 32'h5, 32'h0, 1'b1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    `CHK({ss_n_o, irq}, 2'b10)
    apb(1'b0, CFG_ONE_ADDR, 32'h0);
    `CHK(rd, 32'h10)
    apb(1'b0, CTRL_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      `CHK(er, rows[i].e)
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].x)
    end
    $display("test registers done");
    apb(1'b1, CTRL_ADDR, 32'h3);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, CFG_ONE_ADDR, 32'h10 | r);
      go(8'ha5 ^ 8'(r), 8'h5a ^ 8'(r));
      fin(8'ha5 ^ 8'(r), 8);
      `CHK(per, 8 << r)
      apb(1'b0, RX_ADDR, 32'h0);
      `CHK(rd[7:0], 8'h5a ^ 8'(r))
    end
    $display("test rates done");
    apb(1'b1, MASK_ADDR, 32'h1);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, STAT_ADDR, 32'h7);
      apb(1'b1, CFG_ONE_ADDR, 32'h10 | (s << 5));
      go(8'h0f, 8'hf0);
      repeat (4) @(negedge pclk);
      `CHK(irq, 1'(s))
      fin(8'h0f, 8);
      `CHK(irq, 1'b1)
      apb(1'b0, RX_ADDR, 32'h0);
    end
    apb(1'b1, MASK_ADDR, 32'h0);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, STAT_ADDR, 32'h7);
    $display("test interrupt done");
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, CFG_ONE_ADDR, 32'h10 | (p << 2));
      go(8'h11, 8'h3c);
      fin(8'h11, 8);
      go(8'h22, 8'hc3);
      fin(8'h22, 8);
      apb(1'b0, RX_ADDR, 32'h0);
      `CHK(rd[7:0], p ? 8'hc3 : 8'h3c)
      apb(1'b0, STAT_ADDR, 32'h0);
      `CHK(rd[IRQ_OVF], 1'b1)
      apb(1'b1, STAT_ADDR, 32'h7);
    end
    $display("test overflow done");
    apb(1'b1, CTRL_ADDR, 32'h7);
    go(8'h5a, 8'h00);
    apb(1'b1, TX_ADDR, 32'h96);
    fin(8'h96, 16);
    $display("test continuous done");
    apb(1'b1, CFG_ONE_ADDR, 32'h0);
    repeat (3) @(negedge pclk);
    `CHK({ss_n_oe, ss_n_o}, 2'b10)
    apb(1'b1, CTRL_ADDR, 32'h1);
    repeat (2) @(negedge pclk);
    `CHK({sclk_oe, ss_n_oe}, 2'b00)
    $display("test select done");
    apb(1'b1, CFG_ONE_ADDR, 32'h2f);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_ONE_ADDR, 32'h0);
    `CHK(rd, 32'h10)
    $display("test reset done");
    end_sim();
  end
endmodule
